// ### src/fsp_pkg.sv
// ****************************************************************
// flow-through burst sram port: shared constants and types
// ****************************************************************
package fsp_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int FSP_ADDR_W     = 18;
    localparam int FSP_MEM_WORDS  = 262144;
    localparam int FSP_LANES      = 4;
    localparam int FSP_BYTE_W     = 8;
    localparam int FSP_LANE_W     = FSP_BYTE_W + 1;
    localparam int FSP_DATA_W     = FSP_LANES * FSP_BYTE_W;
    localparam int FSP_WORD_W     = FSP_LANES * FSP_LANE_W;
    localparam int FSP_BURST_W    = 2;
    localparam int FSP_FIFO_DEPTH = 4;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [FSP_BURST_W-1:0] FSP_CNT_RST  = 2'h0;
    localparam logic [FSP_ADDR_W-1:0]  FSP_ADDR_RST = 18'h0_0000;
    localparam logic [FSP_WORD_W-1:0]  FSP_WORD_RST = 36'h0_0000_0000;
    localparam logic [FSP_LANES-1:0]   FSP_BW_RST   = 4'hf;
    localparam logic                   FSP_OE_N_RST = 1'b1;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_READ,
        FSP_WRITE
    } fsp_op_type;

    // every pin that enters from the bus master
    typedef struct packed {
        logic [FSP_ADDR_W-1:0] addr;
        logic [FSP_LANES-1:0]  bw_n;
        logic                  write_n;
        logic                  adv;
        logic                  cen_n;
        logic                  cs1_n;
        logic                  cs2;
        logic                  cs3_n;
        logic                  oe_n;
        logic                  sleep;
        logic                  interleave;
        logic [FSP_DATA_W-1:0] data;
        logic [FSP_LANES-1:0]  par;
    } fsp_pins_type;

    // one queued write to the array
    typedef struct packed {
        logic [FSP_ADDR_W-1:0] addr;
        logic [FSP_LANES-1:0]  bw_n;
        logic [FSP_WORD_W-1:0] word;
    } fsp_wr_type;

    localparam fsp_pins_type FSP_PINS_RST = '{
        addr: FSP_ADDR_RST, bw_n: FSP_BW_RST, write_n: 1'b1, adv: 1'b0,
        cen_n: 1'b1, cs1_n: 1'b1, cs2: 1'b0, cs3_n: 1'b1,
        oe_n: FSP_OE_N_RST, sleep: 1'b0, interleave: 1'b1,
        data: 32'h0000_0000, par: 4'h0};

endpackage

// ### src/fsp_port.sv
`timescale 1ns/1ps

// ****************************************************************
// write queue
// ****************************************************************
module fsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("fifo depth must be a power of two, at least two");
        end
    endgenerate

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PTR_W-1:0] wptr_q;
    logic [PTR_W-1:0] wptr_d;
    logic [PTR_W-1:0] rptr_q;
    logic [PTR_W-1:0] rptr_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready  = (cnt_q != FULL_CNT);
        out_valid = (cnt_q != '0);
        out_data  = store_q[rptr_q];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wptr_d    = push ? wptr_q + 1'b1 : wptr_q;
        rptr_d    = pop ? rptr_q + 1'b1 : rptr_q;
        cnt_d     = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q  <= cnt_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            store_q[wptr_q] <= in_data;
        end
    end

endmodule // fsp_fifo

// ****************************************************************
// sram port top
// ****************************************************************
module fsp_port #(
    parameter int MEM_WORDS  = fsp_pkg::FSP_MEM_WORDS,
    parameter int FIFO_DEPTH = fsp_pkg::FSP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    // address and burst start
    input  wire logic [fsp_pkg::FSP_ADDR_W-1:2]  addr_upper,
    input  wire logic                            burst_addr_bit_one,
    input  wire logic                            burst_addr_bit_zero,
    // write controls
    input  wire logic                            byte_lane_write_n_lane0,
    input  wire logic                            byte_lane_write_n_lane1,
    input  wire logic                            byte_lane_write_n_lane2,
    input  wire logic                            byte_lane_write_n_lane3,
    input  wire logic                            write_n,
    // cycle controls
    input  wire logic                            advance_or_load,
    input  wire logic                            clock_qualify_n,
    input  wire logic                            chip_select_first_n,
    input  wire logic                            chip_select_second,
    input  wire logic                            chip_select_third_n,
    input  wire logic                            out_enable_n,
    input  wire logic                            sleep_request,
    input  wire logic                            burst_order_strap,
    // data pins
    input  wire logic [fsp_pkg::FSP_DATA_W-1:0]  dq_in,
    output logic [fsp_pkg::FSP_DATA_W-1:0]       dq_out,
    output logic                                 dq_oe_n,
    // parity pins
    input  wire logic [fsp_pkg::FSP_LANES-1:0]   parity_data_lines_in,
    output logic [fsp_pkg::FSP_LANES-1:0]        parity_data_lines_out,
    output logic                                 parity_data_lines_oe_n
);
    import fsp_pkg::*;

    localparam int IDX_W = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;
    localparam int WR_W  = $bits(fsp_wr_type);

    generate
        if (MEM_WORDS < 4 || (MEM_WORDS & (MEM_WORDS - 1)) != 0 ||
            MEM_WORDS > (1 << FSP_ADDR_W)) begin : g_bad_words
            $error("array size must be a power of two within the map");
        end
    endgenerate

    // ************************************************************
    // input synchroniser
    // ************************************************************
    fsp_pins_type pins;
    fsp_pins_type sync1_q;
    fsp_pins_type sync1_d;
    fsp_pins_type s;

    always_comb begin
        pins.addr       = {addr_upper, burst_addr_bit_one,
                           burst_addr_bit_zero};
        pins.bw_n       = {byte_lane_write_n_lane3, byte_lane_write_n_lane2,
                           byte_lane_write_n_lane1, byte_lane_write_n_lane0};
        pins.write_n    = write_n;
        pins.adv        = advance_or_load;
        pins.cen_n      = clock_qualify_n;
        pins.cs1_n      = chip_select_first_n;
        pins.cs2        = chip_select_second;
        pins.cs3_n      = chip_select_third_n;
        pins.oe_n       = out_enable_n;
        // low sleep pin is ordinary running
        pins.sleep      = sleep_request;
        pins.interleave = burst_order_strap;
        pins.data       = dq_in;
        pins.par        = parity_data_lines_in;
        sync1_d         = pins;
    end

    // every pin is asynchronous to core_clk, so two stages each
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= FSP_PINS_RST;
            s       <= FSP_PINS_RST;
        end else begin
            sync1_q <= sync1_d;
            s       <= sync1_q;
        end
    end

    // ************************************************************
    // write queue and array
    // ************************************************************
    fsp_wr_type             push_ent;
    logic [FSP_WORD_W-1:0]  push_word;
    fsp_wr_type             head;
    logic [WR_W-1:0]        head_bits;
    logic                   push;
    logic                   fifo_ready;
    logic                   head_valid;
    logic                   drain;
    logic [IDX_W-1:0]       head_idx;
    logic [IDX_W-1:0]       rd_idx;
    logic [FSP_ADDR_W-1:0]  cur_addr;
    logic [FSP_WORD_W-1:0]  rd_word;

    // draining stops in sleep, the array only retains
    assign drain    = !s.sleep;
    assign head     = fsp_wr_type'(head_bits);
    assign head_idx = head.addr[IDX_W-1:0];
    assign rd_idx   = cur_addr[IDX_W-1:0];

    fsp_fifo #(
        .WIDTH (WR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (WR_W'(push_ent)),
        .out_valid (head_valid),
        .out_ready (drain),
        .out_data  (head_bits)
    );

    genvar ln;
    generate
        for (ln = 0; ln < FSP_LANES; ln++) begin : g_lane
            logic [FSP_LANE_W-1:0] lane_q [MEM_WORDS];
            logic [FSP_LANE_W-1:0] lane_rd;

            // a lane is stored only when its own select is low
            always_ff @(posedge core_clk) begin
                if (head_valid && drain && !head.bw_n[ln]) begin
                    lane_q[head_idx] <= head.word[ln*FSP_LANE_W +:
                                                  FSP_LANE_W];
                end
            end

            // newest write wins: the one entering now, then queue head
            always_comb begin
                lane_rd = lane_q[rd_idx];
                if (head_valid && head.addr == cur_addr && !head.bw_n[ln]) begin
                    lane_rd = head.word[ln*FSP_LANE_W +: FSP_LANE_W];
                end
                if (push && push_ent.addr == cur_addr &&
                    !push_ent.bw_n[ln]) begin
                    lane_rd = push_ent.word[ln*FSP_LANE_W +: FSP_LANE_W];
                end
            end
            assign rd_word[ln*FSP_LANE_W +: FSP_LANE_W] = lane_rd;

            // parity bit rides in its lane's ninth bit
            assign push_word[ln*FSP_LANE_W +: FSP_LANE_W] =
                {s.par[ln], s.data[ln*FSP_BYTE_W +: FSP_BYTE_W]};
        end
    endgenerate

    // ************************************************************
    // access sequencer
    // ************************************************************
    fsp_op_type             op_q;
    fsp_op_type             op_d;
    logic [FSP_ADDR_W-1:0]  base_q;
    logic [FSP_ADDR_W-1:0]  base_d;
    logic [FSP_BURST_W-1:0] cnt_q;
    logic [FSP_BURST_W-1:0] cnt_d;
    logic [FSP_BURST_W-1:0] low;
    logic                   pend_q;
    logic                   pend_d;
    logic [FSP_ADDR_W-1:0]  waddr_q;
    logic [FSP_ADDR_W-1:0]  waddr_d;
    logic [FSP_LANES-1:0]   wbw_q;
    logic [FSP_LANES-1:0]   wbw_d;
    logic [FSP_WORD_W-1:0]  word_q;
    logic [FSP_WORD_W-1:0]  word_d;
    logic                   rd_q;
    logic                   rd_d;
    logic                   oe_n_d;
    logic                   go;
    logic                   sel;

    always_comb begin
        // a high qualifier or a full queue holds the sequencer; output enable and queue draining still act
        go  = !s.cen_n && !s.sleep && fifo_ready;
        sel = !s.cs1_n && s.cs2 && !s.cs3_n;

        op_d    = op_q;
        base_d  = base_q;
        cnt_d   = cnt_q;
        pend_d  = pend_q;
        waddr_d = waddr_q;
        wbw_d   = wbw_q;
        word_d  = word_q;
        rd_d    = rd_q;

        // data phase of the write loaded one qualified edge earlier
        push            = go && pend_q;
        push_ent.addr   = waddr_q;
        push_ent.bw_n   = wbw_q;
        push_ent.word   = push_word;

        if (go) begin
            if (!s.adv) begin
                // strobe sampled on this qualified edge
                if (sel) begin
                    op_d = s.write_n ? FSP_READ : FSP_WRITE;
                end else begin
                    op_d = FSP_IDLE;
                end
                base_d = s.addr;
                cnt_d  = FSP_CNT_RST;
            end else if (op_q != FSP_IDLE) begin
                // advance keeps the operation and steps the burst
                cnt_d = cnt_q + 1'b1;
            end
        end

        if (s.interleave) begin
            low = base_d[FSP_BURST_W-1:0] ^ cnt_d;
        end else begin
            low = base_d[FSP_BURST_W-1:0] + cnt_d;
        end
        cur_addr = {base_d[FSP_ADDR_W-1:FSP_BURST_W], low};

        if (go) begin
            pend_d  = (op_d == FSP_WRITE);
            waddr_d = cur_addr;
            wbw_d   = s.bw_n;
            // flow-through read of this edge's address
            if (op_d == FSP_READ) begin
                word_d = rd_word;
            end
            // no drive in write phase, deselect, or just after it
            // a burst never resumes out of deselect
            rd_d = (op_d == FSP_READ) && (op_q != FSP_IDLE || !s.adv) &&
                   (op_q != FSP_IDLE);
        end

        // enable acts on every edge, frozen or not
        oe_n_d = !(rd_d && !s.oe_n && !s.sleep);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_q                   <= FSP_IDLE;
            base_q                 <= FSP_ADDR_RST;
            cnt_q                  <= FSP_CNT_RST;
            pend_q                 <= 1'b0;
            waddr_q                <= FSP_ADDR_RST;
            wbw_q                  <= FSP_BW_RST;
            word_q                 <= FSP_WORD_RST;
            rd_q                   <= 1'b0;
            dq_oe_n                <= FSP_OE_N_RST;
            parity_data_lines_oe_n <= FSP_OE_N_RST;
        end else begin
            op_q                   <= op_d;
            base_q                 <= base_d;
            cnt_q                  <= cnt_d;
            pend_q                 <= pend_d;
            waddr_q                <= waddr_d;
            wbw_q                  <= wbw_d;
            word_q                 <= word_d;
            rd_q                   <= rd_d;
            dq_oe_n                <= oe_n_d;
            // parity pins follow the data pins exactly
            parity_data_lines_oe_n <= oe_n_d;
        end
    end

    // ************************************************************
    // output data split back into pins
    // ************************************************************
    generate
        for (ln = 0; ln < FSP_LANES; ln++) begin : g_out
            assign dq_out[ln*FSP_BYTE_W +: FSP_BYTE_W] =
                word_q[ln*FSP_LANE_W +: FSP_BYTE_W];
            assign parity_data_lines_out[ln] =
                word_q[ln*FSP_LANE_W + FSP_BYTE_W];
        end
    endgenerate

endmodule // fsp_port

// ### tb/fsp_port_chk_sva.sv
`timescale 1ns/1ps
// ********
// port checker
// ********
module fsp_port_chk (
    // clock and reset
    input wire logic                           core_clk,
    input wire logic                           rst,
    // cycle controls
    input wire logic                           clock_qualify_n,
    input wire logic                           chip_select_first_n,
    input wire logic                           chip_select_second,
    input wire logic                           chip_select_third_n,
    input wire logic                           write_n,
    input wire logic                           advance_or_load,
    input wire logic                           out_enable_n,
    input wire logic                           sleep_request,
    // data pins
    input wire logic [fsp_pkg::FSP_DATA_W-1:0] dq_out,
    input wire logic                           dq_oe_n,
    input wire logic                           parity_data_lines_oe_n
);
    import fsp_pkg::*;
    logic [2:0] age_q;
    logic       live;
    logic       qual;
    logic       sel;
    logic       q_des;
    logic       q_sel;
    logic       q_wr;
    logic       q_rd;

    // pins seen before a reset must not count after it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            age_q <= 3'h0;
        else if (age_q != 3'h4)
            age_q <= age_q + 3'h1;
    end
    assign live = (age_q == 3'h4);
    assign qual = !clock_qualify_n && !sleep_request;
    assign sel = !chip_select_first_n && chip_select_second
                 && !chip_select_third_n;
    assign q_des = qual && !sel && !advance_or_load;
    assign q_sel = qual && sel;
    assign q_wr = q_sel && !write_n && !advance_or_load;
    assign q_rd = q_sel && write_n && !advance_or_load && !out_enable_n;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_oe_high;
        live && $past(out_enable_n, 3) |-> dq_oe_n;
    endproperty
    a_oe_high: assert property (p_oe_high)
        else $error("data driven while enable high");
    property p_par_oe;
        parity_data_lines_oe_n == dq_oe_n;
    endproperty
    a_par_oe: assert property (p_par_oe)
        else $error("parity enable differs from data enable");
    property p_desel;
        live && $past(q_des, 3) |-> dq_oe_n;
    endproperty
    a_desel: assert property (p_desel)
        else $error("driven while deselected");
    property p_wr_float;
        live && $past(q_wr, 3) |-> dq_oe_n;
    endproperty
    a_wr_float: assert property (p_wr_float)
        else $error("driven during a write");
    property p_first;
        live && $past(q_des, 4) && $past(q_sel, 3) |-> dq_oe_n;
    endproperty
    a_first: assert property (p_first)
        else $error("driven on first cycle after deselect");
    property p_freeze;
        live && $past(clock_qualify_n, 2) |-> ##1 $stable(dq_out);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("output moved on a frozen cycle");
    property p_sleep;
        live && $past(sleep_request, 3) && $past(sleep_request, 4)
            |-> dq_oe_n && $stable(dq_out);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("activity while asleep");
    property p_read;
        live && $past(q_sel, 4) && !$past(advance_or_load, 4) &&
            $past(q_rd, 3) |-> !dq_oe_n;
    endproperty
    a_read: assert property (p_read)
        else $error("read did not drive");

    c_read: cover property (live && $past(q_sel, 4) && $past(q_rd, 3));
    c_burst: cover property (q_sel && advance_or_load);
    c_freeze: cover property (live && clock_qualify_n ##1 clock_qualify_n);
endmodule // fsp_port_chk

bind fsp_port fsp_port_chk u_chk (.*);

// ### tb/fsp_master.sv
`timescale 1ns/1ps
// ********
// bus master model
// ********
module fsp_master (
    // clock
    input  wire logic             core_clk,
    // pins toward the port
    output fsp_pkg::fsp_pins_type pins
);
    import fsp_pkg::*;
    logic                  pend_v = 1'b0;
    // high while the master itself drives write data onto the wire
    logic                  drv = 1'b0;
    logic [FSP_WORD_W-1:0] pend_q;

    initial pins = FSP_PINS_RST;

    // one cycle of pins; write data waits for the next qualified cycle
    task automatic cyc(input fsp_pins_type p);
        fsp_pins_type n;
        n = p;
        @(posedge core_clk);
        if (pend_v)
            {n.par, n.data} = pend_q;
        else
            // a released bus keeps no stale value
            {n.par, n.data} = ~{pins.par, pins.data};
        drv <= pend_v;
        if (!p.cen_n || !pend_v) begin
            pend_v = !p.cen_n && !p.write_n && !p.cs1_n && p.cs2 && !p.cs3_n;
            pend_q = {p.par, p.data};
        end
        pins <= n;
    endtask
endmodule // fsp_master

// ### tb/testbench.sv
`timescale 1ns/1ps
// ********
// port testbench
// ********
module testbench;
    import fsp_pkg::*;
    localparam int         WORDS = 16;
    localparam logic [2:0] SEL   = 3'h2;
    logic                  core_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  strap = 1'b1;
    fsp_pins_type          pins;
    logic [FSP_DATA_W-1:0] dq_in;
    logic [FSP_DATA_W-1:0] dq_out;
    logic [FSP_LANES-1:0]  par_in;
    logic [FSP_LANES-1:0]  par_out;
    logic                  dq_oe_n;
    logic                  par_oe_n;
    int                    mismatches = 0;
    int                    n_checks = 0;
    logic [FSP_WORD_W-1:0] mem [WORDS];
    logic [37:0]           expq [$];

    always #20 core_clk = ~core_clk;
    // pin latency lets the port's enable lag the master's data phase
    assign dq_in = (m.drv || dq_oe_n) ? pins.data : dq_out;
    assign par_in = (m.drv || par_oe_n) ? pins.par : par_out;

    fsp_master m (.core_clk(core_clk), .pins(pins));
    fsp_port #(.MEM_WORDS(WORDS)) dut (
        .core_clk(core_clk),
        .rst(rst),
        .addr_upper(pins.addr[17:2]),
        .burst_addr_bit_one(pins.addr[1]),
        .burst_addr_bit_zero(pins.addr[0]),
        .byte_lane_write_n_lane0(pins.bw_n[0]),
        .byte_lane_write_n_lane1(pins.bw_n[1]),
        .byte_lane_write_n_lane2(pins.bw_n[2]),
        .byte_lane_write_n_lane3(pins.bw_n[3]),
        .write_n(pins.write_n),
        .advance_or_load(pins.adv),
        .clock_qualify_n(pins.cen_n),
        .chip_select_first_n(pins.cs1_n),
        .chip_select_second(pins.cs2),
        .chip_select_third_n(pins.cs3_n),
        .out_enable_n(pins.oe_n),
        .sleep_request(pins.sleep),
        .burst_order_strap(pins.interleave),
        .dq_in(dq_in),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n),
        .parity_data_lines_in(par_in),
        .parity_data_lines_out(par_out),
        .parity_data_lines_oe_n(par_oe_n)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [36:0] got, input logic [36:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [35:0] wire_of(input logic [35:0] w);
        logic [35:0] r;
        for (int i = 0; i < 4; i++) begin
            r[32+i] = w[9*i+8];
            r[8*i+:8] = w[9*i+:8];
        end
        return r;
    endfunction

    function automatic fsp_pins_type rd(input int a, input logic [2:0] cs);
        fsp_pins_type p;
        p = FSP_PINS_RST;
        p.addr = 18'(a);
        p.cen_n = 1'b0;
        {p.cs1_n, p.cs2, p.cs3_n} = cs;
        p.oe_n = 1'b0;
        p.interleave = strap;
        return p;
    endfunction

    function automatic fsp_pins_type wr(input int a, input logic [3:0] bw,
                                        input logic [35:0] w);
        fsp_pins_type p;
        p = rd(a, SEL);
        p.write_n = 1'b0;
        p.bw_n = bw;
        {p.par, p.data} = wire_of(w);
        return p;
    endfunction

    // one bus cycle; its outcome shows three edges later
    task automatic go(input fsp_pins_type p, input logic [1:0] k,
                      input logic [35:0] e);
        logic [37:0] x;
        m.cyc(p);
        @(negedge core_clk);
        expq.push_back({k, e});
        if (expq.size() > 3) begin
            x = expq.pop_front();
            if (x[37])
                check({36'h0, dq_oe_n}, 37'h1);
            if (x[36])
                check({dq_oe_n, par_out, dq_out}, {1'b0, x[35:0]});
        end
    endtask

    task automatic flush(input string s);
        repeat (3) go(rd(0, 3'h7), 2'h0, 36'h0);
        $display("test %s done", s);
    endtask

    task automatic t_rw();
        fsp_pins_type p;
        logic [35:0]  nw;
        go(rd(0, SEL), 2'h0, 36'h0);
        mem[3] = 36'h1_2345_6789;
        go(wr(3, 4'h0, mem[3]), 2'h2, 36'h0);
        mem[12] = 36'h9_8765_4321;
        go(wr(12, 4'h0, mem[12]), 2'h2, 36'h0);
        go(rd(3, SEL), 2'h1, wire_of(mem[3]));
        p = wr(12, 4'h0, 36'h0);
        p.write_n = 1'b1;
        go(p, 2'h1, wire_of(mem[12]));
        for (int i = 0; i < 4; i++) begin
            nw = ~mem[3];
            go(wr(3, ~(4'h1 << i), nw), 2'h2, 36'h0);
            mem[3][9*i+:9] = nw[9*i+:9];
            go(rd(3, SEL), 2'h1, wire_of(mem[3]));
        end
        flush("rw");
    endtask

    task automatic t_burst(input logic il, input int s);
        fsp_pins_type p;
        int           a;
        strap = il;
        go(rd(0, SEL), 2'h0, 36'h0);
        for (int i = 0; i < 4; i++) begin
            mem[8+i] = 36'ha_5555_0000 + 36'(i);
            go(wr(8 + i, 4'h0, mem[8+i]), 2'h2, 36'h0);
        end
        go(rd(s, SEL), 2'h1, wire_of(mem[s]));
        p = rd(0, SEL);
        p.adv = 1'b1;
        for (int i = 1; i < 6; i++) begin
            a = 8 + (il ? ((s ^ i) & 3) : ((s + i) & 3));
            go(p, 2'h1, wire_of(mem[a]));
        end
        flush("burst");
    endtask

    task automatic t_cs();
        fsp_pins_type p;
        go(rd(3, SEL), 2'h0, 36'h0);
        for (int c = 0; c < 8; c++) begin
            go(rd(3, SEL), 2'h1, wire_of(mem[3]));
            go(rd(3, c[2:0]), (c == 2) ? 2'h1 : 2'h2, wire_of(mem[3]));
            go(rd(3, SEL), (c == 2) ? 2'h1 : 2'h2, wire_of(mem[3]));
        end
        go(rd(3, 3'h7), 2'h2, 36'h0);
        p = rd(3, SEL);
        p.adv = 1'b1;
        go(p, 2'h2, 36'h0);
        flush("select");
    endtask

    task automatic t_oe_freeze();
        fsp_pins_type p;
        go(rd(3, SEL), 2'h0, 36'h0);
        p = rd(3, SEL);
        p.oe_n = 1'b1;
        go(p, 2'h2, 36'h0);
        go(rd(12, SEL), 2'h1, wire_of(mem[12]));
        p = wr(12, 4'h0, 36'h0);
        p.cen_n = 1'b1;
        go(p, 2'h1, wire_of(mem[12]));
        go(p, 2'h1, wire_of(mem[12]));
        go(rd(12, SEL), 2'h1, wire_of(mem[12]));
        flush("freeze");
    endtask

    task automatic t_sleep();
        fsp_pins_type p;
        go(rd(12, SEL), 2'h0, 36'h0);
        p = rd(12, SEL);
        p.sleep = 1'b1;
        go(p, 2'h0, 36'h0);
        repeat (3) go(p, 2'h2, 36'h0);
        go(rd(12, SEL), 2'h0, 36'h0);
        go(rd(12, SEL), 2'h1, wire_of(mem[12]));
        flush("sleep");
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check({dq_oe_n, par_out, dq_out}, 37'h10_0000_0000);
        t_rw();
        t_burst(1'b0, 10);
        t_burst(1'b1, 9);
        t_cs();
        t_oe_freeze();
        t_sleep();
        print_verdict();
    end

    // hang guard
    initial begin
        for (int i = 0; i < 20000; i++)
            @(posedge core_clk);
        mismatches++;
        print_verdict();
    end
endmodule // testbench
